// [rsfi_params.svh]
// Summary of operation
// - Flag bits 7..4 always read zero
// - Low-voltage flag sets; only software clears
// - Bad voltage-select code sets corrupt flag
// - Bad voltage-select code: delayed reset, restore
// - Fast watchdog timeout: full reset, timeout set
// - Sleep watchdog timeout: clear PC, SP only
// - Power-on clears timeout and power-down flags
// - Low-voltage reset keeps timeout, power-down flags
// - Sleep watchdog timeout sets both flags
// - Power-on disables every interrupt source
// - Full reset clears watchdog, time base; restart
// - Power-on switches all timers off
// - Power-on makes every port pin input
// - Power-on zeroes PC, stack at top
// - Memory pointer zero on full resets; PROGRAM_COUNTER_LOW always
// - Accumulator, table registers kept across resets
// - Bad reset-control code: delayed reset, flag
`ifndef RSFI_PARAMS_SVH
`define RSFI_PARAMS_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define RSFI_OFS_FLAGS    8'h00
`define RSFI_OFS_LVSEL    8'h04
`define RSFI_OFS_RSTCTL   8'h08
`define RSFI_OFS_STATUS   8'h0c
`define RSFI_OFS_IRQ_STAT 8'h10
`define RSFI_OFS_IRQ_MASK 8'h14
`define RSFI_OFS_INTR_EN  8'h18
`define RSFI_OFS_TMR_EN   8'h1c
`define RSFI_OFS_PORT_DIR 8'h20
`define RSFI_OFS_PTR      8'h24
`define RSFI_OFS_ACC      8'h28
`define RSFI_OFS_TABLE_POINTER_REG     8'h2c
`define RSFI_OFS_PCL      8'h30
// ****************************************
// Field positions
// ****************************************
`define RSFI_BIT_CTRL     3
`define RSFI_BIT_LV       2
`define RSFI_BIT_CORRUPT  1
`define RSFI_BIT_TO       0
`define RSFI_BIT_PDF      1
// ****************************************
// Reset and code values
// ****************************************
`define RSFI_POR_CODE     8'h55
`define RSFI_ALT_CODE     8'haa
`define RSFI_LV_CODE1     8'h33
`define RSFI_LV_CODE2     8'h99
`define RSFI_DIR_INPUT    8'hff
`define RSFI_SP_TOP       3'h7
// ****************************************
// Timing
// ****************************************
`define RSFI_CLK_MHZ      25
`define RSFI_SRESET_NS    45000
`define RSFI_LVR_NS       120000
`define RSFI_SRESET_CYC   ((`RSFI_SRESET_NS * `RSFI_CLK_MHZ + 999) / 1000)
`define RSFI_LVR_CYC      ((`RSFI_LVR_NS * `RSFI_CLK_MHZ + 999) / 1000)
`define RSFI_WDT_DEFAULT  20'd262143
`endif

// [rsfi_pkg.sv]
package rsfi_pkg;
  // Reset-source flag bits
  typedef struct packed {
    logic ctrl;
    logic lv;
    logic corrupt;
    logic wdt;
  } rsfi_flags_s;
  // Interrupt events, one bit each
  typedef struct packed {
    logic wdt_sleep;
    logic wdt_fast;
    logic reset_control_reg_bad;
    logic low_voltage_select_reg_bad;
    logic low_voltage_reset;
  } rsfi_evt_s;
  // Kind of the last reset
  typedef enum logic [2:0] {
    RK_POR, RK_LVR, RK_LOW_VOLTAGE_SELECT_REG, RK_RESET_CONTROL_REG, RK_WDT_FAST, RK_WDT_SLEEP
  } rsfi_kind_e;
endpackage : rsfi_pkg

// [rsfi_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "rsfi_params.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_top;
  // ****************
  // Stimulus
  // ****************
  logic        clk, rst_n, read, write, lv, slp, halt, wclr;  // Driven inputs
  logic [7:0]  address, d;                                    // Address, read byte
  logic [31:0] wdata, readdata;                               // Bus data
  logic        waitrequest, core_rst, pc_sp_clr, tb_tick, irq;
  logic [7:0]  program_counter_low, intr_en, timer_en, port_dir;              // Init outputs
  logic [2:0]  stack_ptr;                                     // Stack pointer
  logic [7:0]  codes [4] = '{8'h33, 8'h99, 8'haa, 8'h55};     // Defined select codes
  int          failures, checked, h;                          // Counters
  int          hits = 0;                                      // Full resets seen

  rsfi_top #(.WDT_LIMIT(20'd8000)) u_dut (
    .clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(wdata), .readdata(readdata), .waitrequest(waitrequest),
    .lv_low_pin(lv), .sleep_mode(slp), .halt_req(halt), .wdt_clr(wclr),
    .core_rst(core_rst), .pc_sp_clr(pc_sp_clr), .program_counter_low(program_counter_low), .stack_ptr(stack_ptr),
    .intr_en(intr_en), .timer_en(timer_en), .port_dir(port_dir),
    .tb_tick(tb_tick), .irq(irq));

  // Clock, 40 ns
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Count full reset pulses
  always @(posedge clk) begin
    if (rst_n === 1'b1 && core_rst === 1'b1) hits++;
  end

  // ****************
  // Tasks
  // ****************
  // One bus cycle, held until waitrequest low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] v);
    int n;
    n = 0;
    address <= a;
    wdata   <= {24'h0, v};
    read    <= !wr;
    write   <= wr;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 100);
    if (n >= 100) failures++;
    d = readdata[7:0];
    read  <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    bus(1'b1, a, v);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    `CHK(d, e)
  endtask : rd

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // One-cycle pulse on halt or watchdog clear
  task automatic strobe(input logic hlt);
    if (hlt) halt <= 1'b1;
    else wclr <= 1'b1;
    @(posedge clk);
    halt <= 1'b0;
    wclr <= 1'b0;
    @(posedge clk);
  endtask : strobe

  // Wait for a full reset or a sleep timeout pulse
  task automatic wait_hit(input logic sl);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((sl ? pc_sp_clr : core_rst) !== 1'b1 && n < 9000);
    if (n >= 9000) failures++;
    tick(3);
  endtask : wait_hit

  task automatic init_out();
    `CHK(intr_en, 8'h00)
    `CHK(timer_en, 8'h00)
    `CHK(port_dir, `RSFI_DIR_INPUT)
    `CHK(program_counter_low, 8'h00)
    `CHK(stack_ptr, `RSFI_SP_TOP)
  endtask : init_out

  task automatic end_sim();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim

  // ****************
  // Tests
  // ****************
  initial begin
    {rst_n, read, write, lv, slp, halt, wclr} = 7'h0;
    address = 8'h00;
    wdata = 32'h0;
    failures = 0;
    checked = 0;
    tick(3);
    rst_n <= 1'b1;
    tick(4);
    init_out();
    rd(8'h0c, 8'h00);
    rd(8'h00, 8'h00);
    rd(8'h04, `RSFI_POR_CODE);
    wr(8'h28, 8'ha5);
    wr(8'h2c, 8'h3c);
    wr(8'h24, 8'h77);
    wr(8'h18, 8'hff);
    wr(8'h1c, 8'hff);
    wr(8'h20, 8'h00);
    `CHK(intr_en & timer_en & ~port_dir, 8'hff)
    wr(8'hfc, 8'h5a);
    rd(8'hfc, 8'h00);
    // Bad reset control code
    wr(8'h08, 8'h12);
    wait_hit(1'b0);
    `CHK(tb_tick, 1'b0)
    rd(8'h00, 8'h08);
    rd(8'h08, `RSFI_POR_CODE);
    rd(8'h24, 8'h00);
    rd(8'h28, 8'ha5);
    rd(8'h2c, 8'h3c);
    init_out();
    // Mask, raise, clear
    wr(8'h14, 8'h1f);
    `CHK(irq, 1'b1)
    wr(8'h14, 8'h00);
    `CHK(irq, 1'b0)
    wr(8'h14, 8'h1f);
    wr(8'h10, 8'h04);
    `CHK(irq, 1'b0)
    wr(8'h00, 8'hf7);
    rd(8'h00, 8'h00);
    // Bad voltage select code
    wr(8'h04, 8'h00);
    wait_hit(1'b0);
    rd(8'h00, 8'h02);
    rd(8'h04, `RSFI_POR_CODE);
    wr(8'h00, 8'h00);
    h = hits;
    for (int i = 0; i < 4; i++) begin
      wr(8'h04, codes[i]);
      strobe(1'b0);
      tick(1200);
      rd(8'h04, codes[i]);
    end
    `CHK(hits, h)
    // Low voltage, power-down flag set first
    strobe(1'b0);
    strobe(1'b1);
    lv <= 1'b1;
    tick(100);
    lv <= 1'b0;
    tick(10);
    `CHK(hits, h)
    lv <= 1'b1;
    wait_hit(1'b0);
    lv <= 1'b0;
    rd(8'h00, 8'h04);
    bus(1'b0, 8'h0c, 8'h00);
    `CHK(d[5:0], 6'h0a)
    // Fast watchdog timeout after restart
    wait_hit(1'b0);
    bus(1'b0, 8'h0c, 8'h00);
    `CHK(d[5:0], 6'h23)
    rd(8'h00, 8'h04);
    rd(8'h28, 8'ha5);
    // Sleep watchdog timeout
    wr(8'h24, 8'h66);
    wr(8'h30, 8'h5c);
    wr(8'h18, 8'hff);
    slp <= 1'b1;
    h = hits;
    wait_hit(1'b1);
    slp <= 1'b0;
    `CHK(hits, h)
    `CHK({stack_ptr, program_counter_low, intr_en}, 19'h000ff)
    bus(1'b0, 8'h0c, 8'h00);
    `CHK(d[5:0], 6'h2b)
    rd(8'h24, 8'h66);
    // Power-on in mid-run
    rst_n <= 1'b0;
    tick(3);
    rst_n <= 1'b1;
    tick(4);
    init_out();
    rd(8'h0c, 8'h00);
    rd(8'h00, 8'h00);
    end_sim();
  end

  // Hang guard
  initial begin
    repeat (80000) @(posedge clk);
    failures++;
    end_sim();
  end
endmodule : tb_top
`default_nettype wire

// [rsfi_top.sv]
// Decided for this implementation: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "rsfi_params.svh"
module rsfi_top #(
  parameter logic [19:0] WDT_LIMIT = `RSFI_WDT_DEFAULT  // Watchdog period in cycles
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Supply monitor pin
  input  wire logic        lv_low_pin,
  // Core status, same clock
  input  wire logic        sleep_mode,
  input  wire logic        halt_req,
  input  wire logic        wdt_clr,
  // Core init outputs
  output logic             core_rst,
  output logic             pc_sp_clr,
  output logic [7:0]       program_counter_low,
  output logic [2:0]       stack_ptr,
  output logic [7:0]       intr_en,
  output logic [7:0]       timer_en,
  output logic [7:0]       port_dir,
  output logic             tb_tick,
  // Interrupt
  output logic             irq
);
  // ****************************************
  // Reset synchroniser and pin sync
  // ****************************************
  logic [1:0] rst_sr;    // Reset release chain
  logic       por_n;     // Synchronised reset
  logic       lv_s1;     // Pin first stage
  logic       lv_s2;     // Pin second stage

  // Release reset through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sr <= 2'b00;
    end else begin
      rst_sr <= {rst_sr[0], 1'b1};
    end
  end
  assign por_n = rst_sr[1];

  // Two-flop sync of supply monitor
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      lv_s1 <= 1'b0;
      lv_s2 <= 1'b0;
    end else begin
      lv_s1 <= lv_low_pin;
      lv_s2 <= lv_s1;
    end
  end

  // ****************************************
  // Functions
  // ****************************************
  // Voltage select code is one of four
  function automatic logic lv_code_ok(input logic [7:0] c);
    lv_code_ok = (c == `RSFI_POR_CODE) || (c == `RSFI_ALT_CODE) ||
                 (c == `RSFI_LV_CODE1) || (c == `RSFI_LV_CODE2);
  endfunction : lv_code_ok

  // Reset control code is a no-op code
  function automatic logic rst_code_ok(input logic [7:0] c);
    rst_code_ok = (c == `RSFI_POR_CODE) || (c == `RSFI_ALT_CODE);
  endfunction : rst_code_ok

  // ****************************************
  // Bus handshake
  // ****************************************
  logic       ack;       // Answer cycle of a request
  logic       wr_acc;    // Write takes effect
  logic       rd_acc;    // Read completes
  logic [7:0] wd;        // Write data byte

  assign waitrequest = (read | write) & ~ack;
  assign wr_acc      = write & ack;
  assign rd_acc      = read & ack;
  assign wd          = writedata[7:0];

  // One wait cycle per request
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      ack <= 1'b0;
    end else begin
      ack <= (read | write) & ~ack;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  rsfi_pkg::rsfi_flags_s flags;      // Reset-source flags
  rsfi_pkg::rsfi_evt_s   irq_stat;   // Sticky events
  rsfi_pkg::rsfi_evt_s   irq_mask;   // Event enables
  rsfi_pkg::rsfi_evt_s   evt;        // Events this cycle
  rsfi_pkg::rsfi_kind_e  last_kind;  // Last reset kind
  logic [7:0]  lvsel;       // Voltage select
  logic [7:0]  rstctl;      // Reset control
  logic        to_flag;     // Timeout status
  logic        power_down_flag;         // Power-down status
  logic [7:0]  mem_ptr;     // Memory pointer
  logic [7:0]  acc;         // Accumulator, no reset
  logic [7:0]  table_pointer_reg;        // Table pointer, no reset

  // ****************************************
  // Reset sources
  // ****************************************
  logic [11:0] lv_cnt;      // Low-voltage persistence
  logic [11:0] lvsel_cnt;   // Bad select delay
  logic [11:0] rstctl_cnt;  // Bad control delay
  logic [19:0] wdt_cnt;     // Watchdog count
  logic [15:0] tb_cnt;      // Time base count
  logic        lvr_fire;    // Qualified low voltage
  logic        lvsel_fire;  // Bad select expired
  logic        rstctl_fire; // Bad control expired
  logic        wdt_fire;    // Watchdog overflow
  logic        wdt_fast;    // Timeout while running
  logic        wdt_sleep;   // Timeout while asleep
  logic        full_rst;    // Any full reset

  assign lvr_fire    = lv_s2 && !sleep_mode &&
                       (lv_cnt == 12'(`RSFI_LVR_CYC - 1));
  assign lvsel_fire  = !lv_code_ok(lvsel) &&
                       (lvsel_cnt == 12'(`RSFI_SRESET_CYC - 1));
  assign rstctl_fire = !rst_code_ok(rstctl) &&
                       (rstctl_cnt == 12'(`RSFI_SRESET_CYC - 1));
  assign wdt_fire    = (wdt_cnt == WDT_LIMIT - 20'd1);
  assign wdt_fast    = wdt_fire && !sleep_mode;
  assign wdt_sleep   = wdt_fire && sleep_mode;
  assign full_rst    = lvr_fire | lvsel_fire | rstctl_fire | wdt_fast;
  assign evt         = '{wdt_sleep: wdt_sleep, wdt_fast: wdt_fast,
                         reset_control_reg_bad: rstctl_fire, low_voltage_select_reg_bad: lvsel_fire,
                         low_voltage_reset: lvr_fire};

  // Low voltage must persist; off in power-down
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      lv_cnt <= 12'h000;
    end else if (!lv_s2 || sleep_mode) begin
      lv_cnt <= 12'h000;
    end else if (lv_cnt != 12'(`RSFI_LVR_CYC)) begin
      lv_cnt <= lv_cnt + 12'h001;
    end
  end

  // Delay before a bad select code resets
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      lvsel_cnt <= 12'h000;
    end else if (lv_code_ok(lvsel) || lvsel_fire) begin
      lvsel_cnt <= 12'h000;
    end else begin
      lvsel_cnt <= lvsel_cnt + 12'h001;
    end
  end

  // Delay before a bad control code resets
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      rstctl_cnt <= 12'h000;
    end else if (rst_code_ok(rstctl) || rstctl_fire) begin
      rstctl_cnt <= 12'h000;
    end else begin
      rstctl_cnt <= rstctl_cnt + 12'h001;
    end
  end

  // Watchdog restarts from zero after any reset
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      wdt_cnt <= 20'h00000;
    end else if (full_rst || wdt_fire || wdt_clr || halt_req) begin
      wdt_cnt <= 20'h00000;
    end else begin
      wdt_cnt <= wdt_cnt + 20'h00001;
    end
  end

  // Time base cleared by full reset
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      tb_cnt  <= 16'h0000;
      tb_tick <= 1'b0;
    end else if (full_rst) begin
      tb_cnt  <= 16'h0000;
      tb_tick <= 1'b0;
    end else begin
      tb_cnt  <= tb_cnt + 16'h0001;
      tb_tick <= (tb_cnt == 16'hffff);
    end
  end

  // ****************************************
  // Reset-source flags
  // ****************************************
  // Set wins over a software clear
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      flags <= '0;
    end else begin
      if (rstctl_fire) begin
        flags.ctrl <= 1'b1;
      end else if (wr_acc && address == `RSFI_OFS_FLAGS && !wd[`RSFI_BIT_CTRL]) begin
        flags.ctrl <= 1'b0;
      end
      if (lvr_fire) begin
        flags.lv <= 1'b1;
      end else if (wr_acc && address == `RSFI_OFS_FLAGS && !wd[`RSFI_BIT_LV]) begin
        flags.lv <= 1'b0;
      end
      if (lvsel_fire) begin
        flags.corrupt <= 1'b1;
      end else if (wr_acc && address == `RSFI_OFS_FLAGS && !wd[`RSFI_BIT_CORRUPT]) begin
        flags.corrupt <= 1'b0;
      end
      flags.wdt <= 1'b0;
    end
  end

  // Timeout and power-down status
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      to_flag <= 1'b0;
      power_down_flag     <= 1'b0;
    end else if (wdt_fire) begin
      to_flag <= 1'b1;
      power_down_flag     <= power_down_flag | sleep_mode;
    end else if (full_rst) begin
      to_flag <= to_flag;
      power_down_flag     <= power_down_flag;
    end else if (wdt_clr) begin
      to_flag <= 1'b0;
      power_down_flag     <= 1'b0;
    end else if (halt_req) begin
      power_down_flag     <= 1'b1;
    end
  end

  // Record which reset happened last
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      last_kind <= rsfi_pkg::RK_POR;
    end else if (wdt_sleep) begin
      last_kind <= rsfi_pkg::RK_WDT_SLEEP;
    end else if (wdt_fast) begin
      last_kind <= rsfi_pkg::RK_WDT_FAST;
    end else if (lvr_fire) begin
      last_kind <= rsfi_pkg::RK_LVR;
    end else if (lvsel_fire) begin
      last_kind <= rsfi_pkg::RK_LOW_VOLTAGE_SELECT_REG;
    end else if (rstctl_fire) begin
      last_kind <= rsfi_pkg::RK_RESET_CONTROL_REG;
    end
  end

  // ****************************************
  // Code registers
  // ****************************************
  // Bad codes restore the power-on value
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      lvsel  <= `RSFI_POR_CODE;
      rstctl <= `RSFI_POR_CODE;
    end else begin
      if (lvsel_fire) begin
        lvsel <= `RSFI_POR_CODE;
      end else if (wr_acc && address == `RSFI_OFS_LVSEL) begin
        lvsel <= wd;
      end
      if (full_rst) begin
        rstctl <= `RSFI_POR_CODE;
      end else if (wr_acc && address == `RSFI_OFS_RSTCTL) begin
        rstctl <= wd;
      end
    end
  end

  // ****************************************
  // Core initial state
  // ****************************************
  // Full reset reloads controls and pointers
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      intr_en   <= 8'h00;
      timer_en  <= 8'h00;
      port_dir  <= `RSFI_DIR_INPUT;
      mem_ptr   <= 8'h00;
      program_counter_low       <= 8'h00;
      stack_ptr <= `RSFI_SP_TOP;
    end else if (full_rst) begin
      intr_en   <= 8'h00;
      timer_en  <= 8'h00;
      port_dir  <= `RSFI_DIR_INPUT;
      mem_ptr   <= 8'h00;
      program_counter_low       <= 8'h00;
      stack_ptr <= `RSFI_SP_TOP;
    end else if (wdt_sleep) begin
      program_counter_low       <= 8'h00;
      stack_ptr <= 3'h0;                                              // Zero, not top
    end else if (wr_acc) begin
      unique case (address)
        `RSFI_OFS_INTR_EN:  intr_en  <= wd;
        `RSFI_OFS_TMR_EN:   timer_en <= wd;
        `RSFI_OFS_PORT_DIR: port_dir <= wd;
        `RSFI_OFS_PTR:      mem_ptr  <= wd;
        `RSFI_OFS_PCL:      program_counter_low      <= wd;
        default: ;
      endcase
    end
  end

  // Data registers survive every reset
  always_ff @(posedge clk) begin
    if (wr_acc && address == `RSFI_OFS_ACC) begin
      acc <= wd;
    end
    if (wr_acc && address == `RSFI_OFS_TABLE_POINTER_REG) begin
      table_pointer_reg <= wd;
    end
  end

  // Reset pulses to the core
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      core_rst  <= 1'b1;
      pc_sp_clr <= 1'b0;
    end else begin
      core_rst  <= full_rst;
      pc_sp_clr <= wdt_sleep;
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  // Sticky events, write one clears, set wins
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      irq_stat <= '0;
      irq_mask <= '0;
    end else begin
      if (wr_acc && address == `RSFI_OFS_IRQ_STAT) begin
        irq_stat <= (irq_stat & ~rsfi_pkg::rsfi_evt_s'(wd[4:0])) | evt;
      end else begin
        irq_stat <= irq_stat | evt;
      end
      if (wr_acc && address == `RSFI_OFS_IRQ_MASK) begin
        irq_mask <= rsfi_pkg::rsfi_evt_s'(wd[4:0]);
      end
    end
  end
  assign irq = |(irq_stat & irq_mask);

  // ****************************************
  // Read path
  // ****************************************
  logic [7:0] next_rd;  // Selected byte
  always_comb begin
    unique case (address)
      `RSFI_OFS_FLAGS:    next_rd = {4'h0, flags};
      `RSFI_OFS_LVSEL:    next_rd = lvsel;
      `RSFI_OFS_RSTCTL:   next_rd = rstctl;
      `RSFI_OFS_STATUS:   next_rd = {2'b00, last_kind, 1'b0, power_down_flag, to_flag};
      `RSFI_OFS_IRQ_STAT: next_rd = {3'b000, irq_stat};
      `RSFI_OFS_IRQ_MASK: next_rd = {3'b000, irq_mask};
      `RSFI_OFS_INTR_EN:  next_rd = intr_en;
      `RSFI_OFS_TMR_EN:   next_rd = timer_en;
      `RSFI_OFS_PORT_DIR: next_rd = port_dir;
      `RSFI_OFS_PTR:      next_rd = mem_ptr;
      `RSFI_OFS_ACC:      next_rd = acc;
      `RSFI_OFS_TABLE_POINTER_REG:     next_rd = table_pointer_reg;
      `RSFI_OFS_PCL:      next_rd = program_counter_low;
      default:            next_rd = 8'h00;
    endcase
  end

  // Capture read data during the wait cycle
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      readdata <= 32'h0000_0000;
    end else if (read && !ack) begin
      readdata <= {24'h000000, next_rd};
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_full_rst;
    full_rst;
  endsequence
  sequence s_init_seen;
    core_rst && intr_en == 8'h00 && timer_en == 8'h00 && mem_ptr == 8'h00;
  endsequence

  AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (!por_n)
    rd_acc && address == `RSFI_OFS_FLAGS |-> readdata[7:4] == 4'h0)
    else $error("Reserved flag bits read nonzero");
  AST_LV_SET: assert property (@(posedge clk) disable iff (!por_n)
    lvr_fire |=> flags.lv && core_rst)
    else $error("Low-voltage flag not set with reset");
  AST_LV_HOLD: assert property (@(posedge clk) disable iff (!por_n)
    flags.lv && !(wr_acc && address == `RSFI_OFS_FLAGS) |=> flags.lv)
    else $error("Low-voltage flag lost without software");
  AST_LVSEL: assert property (@(posedge clk) disable iff (!por_n)
    lvsel_fire |=> flags.corrupt && lvsel == `RSFI_POR_CODE && core_rst)
    else $error("Bad select code not handled");
  AST_LVSEL_WAIT: assert property (@(posedge clk) disable iff (!por_n)
    $rose(!lv_code_ok(lvsel)) |-> !lvsel_fire [*8])
    else $error("Bad select reset came too early");
  AST_WDT_FAST: assert property (@(posedge clk) disable iff (!por_n)
    wdt_fast |=> to_flag && core_rst && power_down_flag == $past(power_down_flag))
    else $error("Fast watchdog reset wrong");
  AST_WDT_SLEEP: assert property (@(posedge clk) disable iff (!por_n)
    wdt_sleep |=> pc_sp_clr && program_counter_low == 8'h00 && stack_ptr == 3'h0 && !core_rst &&
                  mem_ptr == $past(mem_ptr) && intr_en == $past(intr_en))
    else $error("Sleep watchdog touched other state");
  AST_POR_FLAGS: assert property (@(posedge clk)
    $rose(por_n) |-> !to_flag && !power_down_flag)
    else $error("Power-on did not clear status");
  AST_LVR_KEEP: assert property (@(posedge clk) disable iff (!por_n)
    lvr_fire && !wdt_fire |=> $stable(to_flag) && $stable(power_down_flag))
    else $error("Low-voltage reset changed status");
  AST_SLEEP_FLAGS: assert property (@(posedge clk) disable iff (!por_n)
    wdt_sleep |=> to_flag && power_down_flag)
    else $error("Sleep timeout flags not both set");
  AST_INIT: assert property (@(posedge clk) disable iff (!por_n)
    s_full_rst |=> s_init_seen ##0 port_dir == `RSFI_DIR_INPUT && program_counter_low == 8'h00)
    else $error("Core not initialised by reset");
  AST_WDT_CLR: assert property (@(posedge clk) disable iff (!por_n)
    s_full_rst ##1 !(full_rst || wdt_clr || halt_req) |->
      wdt_cnt == 20'h00000 ##1 wdt_cnt == 20'h00001)
    else $error("Watchdog not restarted after reset");
  AST_ACC_KEEP: assert property (@(posedge clk) disable iff (!por_n)
    (s_full_rst and !wr_acc) |=> acc == $past(acc) && table_pointer_reg == $past(table_pointer_reg))
    else $error("Data register lost on reset");
  AST_RSTCTL: assert property (@(posedge clk) disable iff (!por_n)
    rstctl_fire |=> flags.ctrl && core_rst && rstctl == `RSFI_POR_CODE)
    else $error("Bad control code not handled");
endmodule : rsfi_top
`default_nettype wire
